//--- rtl/ebwc_pkg.sv
package ebwc_pkg;

  // ==========================================================
  // Register map
  localparam logic [7:0]  EBWC_OFS_SPACE_WAIT = 8'h00;
  localparam logic [7:0]  EBWC_OFS_DMA_WAIT   = 8'h04;
  localparam logic [7:0]  EBWC_OFS_RAM_SEL    = 8'h08;
  localparam logic [7:0]  EBWC_OFS_BUS_CTL2   = 8'h0C;
  localparam logic [7:0]  EBWC_OFS_STATUS     = 8'h10;

  // ==========================================================
  // Reset values
  localparam logic [15:0] EBWC_RST_SPACE_WAIT = 16'hFFFF;
  localparam logic [3:0]  EBWC_RST_DMA_WAIT   = 4'hF;
  localparam logic [15:0] EBWC_RST_RAM_SEL    = 16'h0000;
  localparam logic [3:0]  EBWC_RST_EXTEND     = 4'hF;

  // ==========================================================
  // Field layout
  localparam int          EBWC_WAIT_FIELD_W   = 4;
  localparam logic [3:0]  EBWC_WAIT_NONE      = 4'h0;
  localparam logic [3:0]  EBWC_WAIT_LAST      = 4'h1;

  // ==========================================================
  // Bus width encodings
  localparam logic [1:0]  EBWC_WIDTH_8        = 2'h0;
  localparam logic [1:0]  EBWC_WIDTH_16       = 2'h1;
  localparam logic [1:0]  EBWC_WIDTH_32       = 2'h2;
  localparam logic [31:0] EBWC_MASK_8         = 32'h0000_00FF;
  localparam logic [31:0] EBWC_MASK_16        = 32'h0000_FFFF;
  localparam logic [31:0] EBWC_MASK_32        = 32'hFFFF_FFFF;

  // ==========================================================
  // Access states
  typedef enum logic [2:0] {
    EBWC_IDLE,
    EBWC_LEAD,
    EBWC_T1,
    EBWC_TW,
    EBWC_T2,
    EBWC_TRAIL
  } ebwc_state_t;

  // ==========================================================
  // Access request
  typedef struct packed {
    logic [2:0]  cs;
    logic        write;
    logic        dma_single;
    logic [3:0]  be;
    logic [1:0]  width;
    logic [31:0] wdata;
  } ebwc_req_t;

endpackage : ebwc_pkg

//--- rtl/ebwc_wait_sel.sv
`timescale 1ns/1ps

// ==========================================================
// Wait count selection per access
module ebwc_wait_sel
  import ebwc_pkg::*;
(
  // Configuration
  input  wire logic [15:0] space_wait_cfg,
  input  wire logic [3:0]  dma_wait_cfg,
  // Access
  input  wire logic [1:0]  pair,
  input  wire logic        dma_single,
  // Result
  output logic      [3:0]  wait_count,
  output logic             ext_wait_en
);

  always_comb
  begin
    if (dma_single)
      wait_count = dma_wait_cfg;
    else
      wait_count = space_wait_cfg[pair*EBWC_WAIT_FIELD_W +: EBWC_WAIT_FIELD_W];
    ext_wait_en = (wait_count != EBWC_WAIT_NONE);
  end

endmodule : ebwc_wait_sel

//--- rtl/ebwc_lane_strobe.sv
`timescale 1ns/1ps

// ==========================================================
// One byte-lane write strobe, active low
module ebwc_lane_strobe
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  // Control
  input  wire logic active,
  input  wire logic lane_en,
  // Pin
  output logic      strobe_n_r
);

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      strobe_n_r <= 1'b1;
    else
      strobe_n_r <= ~(active & lane_en);
  end

endmodule : ebwc_lane_strobe

//--- rtl/ebwc_top.sv
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps

// Behaviour
// - One 4-bit wait field per space pair
// - Zero field: no waits, wait pin ignored
// - Nonzero N: N waits, wait pin sampled
// - Separate DMA single-address wait count
// - DMA count zero disables, N adds waits
// - DMA register upper bits read zero
// - No-wait access takes two states
// - Read captures full configured bus width
// - Four active-low byte write strobes
// - Waits sit between first and final
// - Wait pin sampled one edge early
// - Extension adds one state each side
// - Extension states assert chip select, no strobes
// - Write data held through trailing extension
// - Extension bit set adds exactly two
// - Flash emulation RAM select register
module ebwc_top
  import ebwc_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata_r,
  output logic      [15:0] ram_select_r,
  // Access request and answer
  input  wire logic        acc_valid,
  input  wire ebwc_req_t   acc_req,
  output logic             acc_ready_r,
  output logic             acc_done_r,
  output logic      [31:0] acc_rdata_r,
  // External bus
  output logic      [7:0]  chip_select_n_r,
  output logic             read_strobe_n_r,
  output logic      [3:0]  write_strobe_n_r,
  output logic      [31:0] data_out_r,
  output logic             data_oe_r,
  input  wire logic [31:0] data_in,
  input  wire logic        ext_wait_n
);

  // ==========================================================
  // Registers
  logic [15:0] space_wait_r;
  logic [3:0]  dma_wait_r;
  logic [3:0]  extend_r;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      space_wait_r <= EBWC_RST_SPACE_WAIT;
      dma_wait_r   <= EBWC_RST_DMA_WAIT;
      ram_select_r <= EBWC_RST_RAM_SEL;
      extend_r     <= EBWC_RST_EXTEND;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        EBWC_OFS_SPACE_WAIT: space_wait_r <= reg_wdata;
        EBWC_OFS_DMA_WAIT:   dma_wait_r   <= reg_wdata[3:0];
        EBWC_OFS_RAM_SEL:    ram_select_r <= reg_wdata;
        EBWC_OFS_BUS_CTL2:   extend_r     <= reg_wdata[3:0];
        default:             ;
      endcase
    end
  end

  // ==========================================================
  // Access sequencer
  ebwc_state_t state_r;
  ebwc_state_t state_nxt;
  ebwc_req_t   req_r;
  logic [3:0]  wait_cnt_r;
  logic [3:0]  wait_cnt_nxt;
  logic        wait_en_r;
  logic        ext_r;
  logic        wait_seen_r;
  logic [3:0]  sel_count;
  logic        sel_wait_en;
  logic        accept;

  assign accept = acc_valid & acc_ready_r;

  ebwc_wait_sel u_wait_sel
  (
    .space_wait_cfg (space_wait_r),
    .dma_wait_cfg   (dma_wait_r),
    .pair           (acc_req.cs[1:0]),
    .dma_single     (acc_req.dma_single),
    .wait_count     (sel_count),
    .ext_wait_en    (sel_wait_en)
  );

  always_comb
  begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    case (state_r)
      EBWC_IDLE:
      begin
        if (accept)
        begin
          wait_cnt_nxt = sel_count;
          if (extend_r[acc_req.cs[1:0]])
            state_nxt = EBWC_LEAD;
          else
            state_nxt = EBWC_T1;
        end
      end
      EBWC_LEAD:
        state_nxt = EBWC_T1;
      EBWC_T1:
      begin
        if (wait_cnt_r == EBWC_WAIT_NONE)
          state_nxt = EBWC_T2;
        else
          state_nxt = EBWC_TW;
      end
      EBWC_TW:
      begin
        if (wait_cnt_r > EBWC_WAIT_LAST)
          wait_cnt_nxt = wait_cnt_r - 4'h1;
        else if (!(wait_en_r && wait_seen_r))
          state_nxt = EBWC_T2;
      end
      EBWC_T2:
      begin
        if (ext_r)
          state_nxt = EBWC_TRAIL;
        else
          state_nxt = EBWC_IDLE;
      end
      EBWC_TRAIL:
        state_nxt = EBWC_IDLE;
      default:
        state_nxt = EBWC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      state_r    <= EBWC_IDLE;
      wait_cnt_r <= EBWC_WAIT_NONE;
    end
    else
    begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // Request latch
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      req_r     <= '0;
      wait_en_r <= 1'b0;
      ext_r     <= 1'b0;
    end
    else if (accept)
    begin
      req_r     <= acc_req;
      wait_en_r <= sel_wait_en;
      ext_r     <= extend_r[acc_req.cs[1:0]];
    end
  end

  // Wait pin sample, read one edge later
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      wait_seen_r <= 1'b0;
    else
      wait_seen_r <= ~ext_wait_n;
  end

  // ==========================================================
  // Pin drivers
  logic strobe_nxt;
  logic cs_nxt;
  logic [2:0] cs_idx;

  assign strobe_nxt = (state_nxt == EBWC_T1) || (state_nxt == EBWC_TW) || (state_nxt == EBWC_T2);
  assign cs_nxt     = (state_nxt != EBWC_IDLE);
  assign cs_idx     = (state_r == EBWC_IDLE) ? acc_req.cs : req_r.cs;

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      chip_select_n_r <= 8'hFF;
      read_strobe_n_r <= 1'b1;
    end
    else
    begin
      chip_select_n_r <= cs_nxt ? ~(8'h01 << cs_idx) : 8'hFF;
      read_strobe_n_r <= ~(strobe_nxt & ~((state_r == EBWC_IDLE) ? acc_req.write : req_r.write));
    end
  end

  logic       wr_active;
  logic [3:0] lane_be;

  assign wr_active = strobe_nxt & ((state_r == EBWC_IDLE) ? acc_req.write : req_r.write);
  assign lane_be   = (state_r == EBWC_IDLE) ? acc_req.be : req_r.be;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      ebwc_lane_strobe u_lane
      (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .active     (wr_active),
        .lane_en    (lane_be[g]),
        .strobe_n_r (write_strobe_n_r[g])
      );
    end
  endgenerate

  // Write data, held into trailing extension
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      data_out_r <= '0;
      data_oe_r  <= 1'b0;
    end
    else
    begin
      if (accept)
        data_out_r <= acc_req.wdata;
      data_oe_r <= (state_nxt != EBWC_IDLE) && (state_nxt != EBWC_LEAD)
                   && ((state_r == EBWC_IDLE) ? acc_req.write : req_r.write);
    end
  end

  // ==========================================================
  // Answer
  logic [31:0] width_mask;

  always_comb
  begin
    case (req_r.width)
      EBWC_WIDTH_8:  width_mask = EBWC_MASK_8;
      EBWC_WIDTH_16: width_mask = EBWC_MASK_16;
      default:       width_mask = EBWC_MASK_32;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      acc_rdata_r <= '0;
      acc_done_r  <= 1'b0;
      acc_ready_r <= 1'b0;
    end
    else
    begin
      if (state_r == EBWC_T2 && !req_r.write)
        acc_rdata_r <= data_in & width_mask;
      acc_done_r  <= (state_nxt == EBWC_IDLE) && (state_r != EBWC_IDLE);
      acc_ready_r <= (state_nxt == EBWC_IDLE);
    end
  end

  // ==========================================================
  // Register read
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      reg_rdata_r <= '0;
    else if (reg_rd)
    begin
      case (reg_addr)
        EBWC_OFS_SPACE_WAIT: reg_rdata_r <= space_wait_r;
        EBWC_OFS_DMA_WAIT:   reg_rdata_r <= {12'h000, dma_wait_r};
        EBWC_OFS_RAM_SEL:    reg_rdata_r <= ram_select_r;
        EBWC_OFS_BUS_CTL2:   reg_rdata_r <= {12'h000, extend_r};
        EBWC_OFS_STATUS:     reg_rdata_r <= {5'h00, wait_seen_r, wait_cnt_r, 3'h0, state_r};
        default:             reg_rdata_r <= 16'h0000;
      endcase
    end
    else
      reg_rdata_r <= 16'h0000;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  logic [4:0] wait_run_r;
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || state_r != EBWC_TW)
      wait_run_r <= '0;
    else if (wait_run_r != 5'h1F)
      wait_run_r <= wait_run_r + 5'h01;
  end

  dma_upper_zero_a: assert property (
    $past(reg_rd) && $past(reg_addr) == EBWC_OFS_DMA_WAIT |-> reg_rdata_r[15:4] == 12'h000)
    else $error("dma wait upper bits not zero");

  zero_wait_a: assert property (
    state_r == EBWC_T1 && wait_cnt_r == EBWC_WAIT_NONE |=> state_r == EBWC_T2)
    else $error("zero wait did not go to final state");

  sw_wait_a: assert property (
    state_r == EBWC_T1 && wait_cnt_r != EBWC_WAIT_NONE |=> state_r == EBWC_TW && wait_en_r)
    else $error("nonzero wait missing wait state");

  basic_two_a: assert property (
    state_r == EBWC_IDLE && accept && !extend_r[acc_req.cs[1:0]] && sel_count == EBWC_WAIT_NONE
    |=> !chip_select_n_r[req_r.cs] ##1 !chip_select_n_r[req_r.cs] ##1 chip_select_n_r == 8'hFF)
    else $error("basic access not two states");

  wait_hold_a: assert property (
    state_r == EBWC_TW && wait_cnt_r == EBWC_WAIT_LAST && wait_en_r && wait_seen_r |=> state_r == EBWC_TW)
    else $error("wait pin ignored");

  wait_bound_a: assert property (
    state_r == EBWC_TW && !wait_seen_r && !$past(wait_seen_r) |-> wait_run_r <= 5'h0F)
    else $error("too many wait states");

  ext_strobe_a: assert property (
    state_r == EBWC_LEAD || state_r == EBWC_TRAIL
    |-> read_strobe_n_r && write_strobe_n_r == 4'hF && chip_select_n_r != 8'hFF)
    else $error("strobe active in extension state");

  trail_data_a: assert property (
    state_r == EBWC_TRAIL && req_r.write |-> data_oe_r)
    else $error("write data dropped in trailing extension");

  lead_one_a: assert property (
    state_r == EBWC_LEAD |=> state_r == EBWC_T1)
    else $error("leading extension not one state");

  lane_map_a: assert property (
    state_r == EBWC_T1 && req_r.write |-> write_strobe_n_r == ~req_r.be)
    else $error("byte strobes do not match lanes");

  read_cov_c:  cover property (state_r == EBWC_T2 && !req_r.write ##1 acc_done_r);
  write_cov_c: cover property (state_r == EBWC_TRAIL && req_r.write);
  ext_cov_c:   cover property (state_r == EBWC_TW && wait_seen_r ##1 state_r == EBWC_TW);
  dma_cov_c:   cover property (accept && acc_req.dma_single);

endmodule : ebwc_top

//--- bench/ebwc_mem_model.sv
`timescale 1ns/1ps

// ==========================================================
// External memory with a programmable wait pin
module ebwc_mem_model
(
  // Clock
  input  wire logic        sys_clk,
  // Bus from the controller
  input  wire logic [7:0]  chip_select_n_r,
  input  wire logic        read_strobe_n_r,
  input  wire logic [3:0]  write_strobe_n_r,
  input  wire logic [31:0] data_out_r,
  input  wire logic        data_oe_r,
  // Strobe cycles to hold the wait pin low
  input  wire logic [3:0]  wait_hold,
  // Back to the controller
  output logic      [31:0] data_in,
  output logic             ext_wait_n
);
  logic [31:0] mem_r  = 32'h8C4E_1A37;
  logic [31:0] idle_r = 32'h0000_0000;
  logic [3:0]  used_r = 4'h0;
  logic        strobe;

  assign strobe     = !read_strobe_n_r || (write_strobe_n_r != 4'hF);
  // Valid from the first strobe cycle, so every sample point sees it
  assign ext_wait_n = !(strobe && (used_r < wait_hold));
  // Released lines show a pattern that moves every cycle
  assign data_in    = !read_strobe_n_r ? mem_r : idle_r;

  always_ff @(posedge sys_clk)
  begin
    idle_r <= {idle_r[30:0], ~idle_r[31]};
    used_r <= (&chip_select_n_r) ? 4'h0 : (strobe && used_r != 4'hF) ? used_r + 4'h1 : used_r;
    for (int i = 0; i < 4; i++)
      if (!write_strobe_n_r[i] && data_oe_r)
        mem_r[8*i +: 8] <= data_out_r[8*i +: 8];
  end
endmodule : ebwc_mem_model

//--- bench/ebwc_top_test.sv
`timescale 1ns/1ps

module ebwc_top_test
  import ebwc_pkg::*;
;
  logic        sys_clk, sys_rst, reg_wr, reg_rd, acc_valid, acc_ready_r, acc_done_r;
  logic        read_strobe_n_r, data_oe_r, ext_wait_n;
  logic [7:0]  reg_addr, chip_select_n_r;
  logic [15:0] reg_wdata, reg_rdata_r, ram_select_r;
  logic [31:0] acc_rdata_r, data_out_r, data_in;
  logic [3:0]  write_strobe_n_r, wait_hold, last_ws;
  ebwc_req_t   acc_req;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cn, sn, on;

  ebwc_top i_ebwc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .ram_select_r(ram_select_r),
    .acc_valid(acc_valid), .acc_req(acc_req), .acc_ready_r(acc_ready_r), .acc_done_r(acc_done_r),
    .acc_rdata_r(acc_rdata_r), .chip_select_n_r(chip_select_n_r), .read_strobe_n_r(read_strobe_n_r),
    .write_strobe_n_r(write_strobe_n_r), .data_out_r(data_out_r), .data_oe_r(data_oe_r),
    .data_in(data_in), .ext_wait_n(ext_wait_n));

  ebwc_mem_model i_ebwc_mem_model (.sys_clk(sys_clk), .chip_select_n_r(chip_select_n_r),
    .read_strobe_n_r(read_strobe_n_r), .write_strobe_n_r(write_strobe_n_r), .data_out_r(data_out_r),
    .data_oe_r(data_oe_r), .wait_hold(wait_hold), .data_in(data_in), .ext_wait_n(ext_wait_n));

  // ==========================================================
  // Shared tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask : reg_write

  task automatic reg_chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    @(negedge sys_clk);
    check("reg_rdata", {16'h0000, reg_rdata_r}, {16'h0000, exp});
  endtask : reg_chk

  // Counts chip select, strobe and data enable cycles of one access
  task automatic access(input logic [2:0] cs, input logic wr, input logic dma, input logic [3:0] be,
                        input logic [1:0] w, input logic [31:0] wd);
    int k;
    cn = 0;
    sn = 0;
    on = 0;
    @(posedge sys_clk);
    acc_valid <= 1'b1;
    acc_req   <= '{cs: cs, write: wr, dma_single: dma, be: be, width: w, wdata: wd};
    for (k = 0; k < 50 && acc_ready_r !== 1'b1; k++)
      @(negedge sys_clk);
    @(posedge sys_clk);
    acc_valid <= 1'b0;
    for (k = 0; k < 60; k++)
    begin
      @(negedge sys_clk);
      if (acc_done_r === 1'b1)
        break;
      cn += (chip_select_n_r[cs] === 1'b0);
      sn += (read_strobe_n_r === 1'b0 || write_strobe_n_r !== 4'hF);
      on += (data_oe_r === 1'b1);
      if (write_strobe_n_r !== 4'hF)
        last_ws = write_strobe_n_r;
    end
    check("done_seen", k < 60, 1'b1);
  endtask : access

  // ==========================================================
  // Scenarios
  task automatic regs_scn;
    reg_chk(EBWC_OFS_SPACE_WAIT, 16'hFFFF);
    reg_chk(EBWC_OFS_DMA_WAIT, 16'h000F);
    reg_chk(EBWC_OFS_RAM_SEL, 16'h0000);
    reg_chk(EBWC_OFS_BUS_CTL2, 16'h000F);
    reg_chk(8'h20, 16'h0000);
    reg_chk(EBWC_OFS_STATUS, 16'h0000);
    reg_write(EBWC_OFS_DMA_WAIT, 16'h0003);
    reg_chk(EBWC_OFS_DMA_WAIT, 16'h0003);
    reg_write(EBWC_OFS_RAM_SEL, 16'hA5C3);
    reg_chk(EBWC_OFS_RAM_SEL, 16'hA5C3);
    check("ram_select", {16'h0000, ram_select_r}, 32'h0000_A5C3);
    reg_write(EBWC_OFS_SPACE_WAIT, 16'h3210);
    reg_chk(EBWC_OFS_SPACE_WAIT, 16'h3210);
    reg_write(EBWC_OFS_BUS_CTL2, 16'h0000);
  endtask : regs_scn

  task automatic pair_scn;
    for (int c = 0; c < 8; c++)
    begin
      access(c[2:0], 1'b0, 1'b0, 4'hF, EBWC_WIDTH_16, 32'h0);
      check("cs_cycles", cn, 2 + c % 4);
      check("strobe_cycles", sn, 2 + c % 4);
      check("rdata16", acc_rdata_r, 32'h0000_1A37);
    end
    access(3'h0, 1'b0, 1'b0, 4'h1, EBWC_WIDTH_8, 32'h0);
    check("rdata8", acc_rdata_r, 32'h0000_0037);
  endtask : pair_scn

  task automatic wait_pin_scn;
    @(posedge sys_clk);
    wait_hold <= 4'h4;
    access(3'h2, 1'b0, 1'b0, 4'hF, EBWC_WIDTH_16, 32'h0);
    check("held_cycles", cn, 7);
    access(3'h0, 1'b0, 1'b0, 4'hF, EBWC_WIDTH_16, 32'h0);
    check("ignored_cycles", cn, 2);
    @(posedge sys_clk);
    wait_hold <= 4'h0;
  endtask : wait_pin_scn

  task automatic dma_scn;
    reg_write(EBWC_OFS_DMA_WAIT, 16'h0005);
    access(3'h0, 1'b0, 1'b1, 4'hF, EBWC_WIDTH_16, 32'h0);
    check("dma_cycles", cn, 7);
    reg_write(EBWC_OFS_DMA_WAIT, 16'h0000);
    wait_hold <= 4'h4;
    access(3'h3, 1'b0, 1'b1, 4'hF, EBWC_WIDTH_16, 32'h0);
    check("dma_zero_cycles", cn, 2);
    @(posedge sys_clk);
    wait_hold <= 4'h0;
  endtask : dma_scn

  task automatic extend_scn;
    reg_write(EBWC_OFS_BUS_CTL2, 16'h0001);
    access(3'h4, 1'b1, 1'b0, 4'h5, EBWC_WIDTH_32, 32'h1122_3344);
    check("ext_cs_cycles", cn, 4);
    check("ext_strobe_cycles", sn, 2);
    check("ext_oe_cycles", on, 3);
    check("lane_strobes", last_ws, 4'hA);
    check("wdata_out", data_out_r, 32'h1122_3344);
    access(3'h0, 1'b0, 1'b0, 4'hF, EBWC_WIDTH_32, 32'h0);
    check("rdata32", acc_rdata_r, 32'h8C22_1A44);
    access(3'h1, 1'b0, 1'b0, 4'hF, EBWC_WIDTH_32, 32'h0);
    check("noext_cycles", cn, 3);
  endtask : extend_scn

  // ==========================================================
  // Clock, run and watchdog
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end

  initial
  begin
    sys_rst   = 1'b1;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 16'h0000;
    acc_valid = 1'b0;
    acc_req   = '0;
    wait_hold = 4'h0;
    last_ws   = 4'hF;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    regs_scn();
    pair_scn();
    wait_pin_scn();
    dma_scn();
    extend_scn();
    summarize();
  end
endmodule : ebwc_top_test
